// *** rtl/lane_map_consts.svh ***
// constants for the converter lane mapper and link control block
`ifndef LANE_MAP_CONSTS_SVH
`define LANE_MAP_CONSTS_SVH
`define ADDR_W 8
`define REG_W 32
`define OFS_FORMAT 8'h00
`define OFS_SYNC 8'h04
`define OFS_BIND 8'h08
`define OFS_CHPD 8'h0C
`define OFS_DEVCFG 8'h10
`define OFS_STATUS 8'h14
`define RST_FORMAT 7'h15
`define MODE_NORMAL 2'h0
`define SYNC_BIT 0
`define BIND_A_BIT 0
`define BIND_B_BIT 1
`define PD_A_BIT 0
`define PD_B_BIT 1
`define ST_PD 0
`define ST_SUP 1
`define ST_RED 2
`define ST_PIN 3
`define ST_FEC 4
`define ST_CLS 8
`define PAD16 16'h0000
`define PAD24 24'h000000
`define FMT_21 7'h15
`define FMT_22 7'h16
`define FMT_23 7'h17
`define FMT_24 7'h18
`define FMT_25 7'h19
`define FMT_26 7'h1A
`define FMT_27 7'h1B
`define FMT_32 7'h20
`define FMT_33 7'h21
`define FMT_34 7'h22
`define FMT_35 7'h23
`define FMT_36 7'h24
`define FMT_37 7'h25
`define FMT_38 7'h26
`define FMT_39 7'h27
`define FMT_46 7'h2E
`define FMT_48 7'h30
`define FMT_52 7'h34
`define FMT_54 7'h36
`define FMT_56 7'h38
`define FMT_61 7'h3D
`define FMT_62 7'h3E
`define FMT_63 7'h3F
`define FMT_64 7'h40
`define FMT_65 7'h41
`define FMT_69 7'h45
`define FMT_70 7'h46
`define FMT_71 7'h47
`endif

// *** rtl/lane_map_pkg.sv ***
// types shared by the lane mapper and its bench
package lane_map_pkg;
	localparam int SIDE = 8;
	typedef enum logic [3:0] {
		FC_NONE = 4'b0000,
		FC_S4_4L = 4'b0001,
		FC_S4_8L = 4'b0010,
		FC_S8_2L = 4'b0011,
		FC_S8_4L = 4'b0100,
		FC_S4_16L = 4'b0101,
		FC_S8_8L = 4'b0110,
		FC_S8_16L = 4'b0111,
		FC_B12_S6 = 4'b1000,
		FC_B12_D6 = 4'b1001,
		FC_B8_S4 = 4'b1010,
		FC_B8_D4 = 4'b1011,
		FC_D4_4L = 4'b1100,
		FC_D_2L = 4'b1101
	} fmt_class_t;
	typedef struct packed {
		logic [7:0][14:0] inphase;
		logic [7:0][14:0] quadrature;
		logic [7:0] overrange_flag_inphase;
		logic [7:0] overrange_flag_quadrature;
		logic [7:0][11:0] raw;
	} chan_t;
	typedef struct packed {
		chan_t chan_a;
		chan_t chan_b;
	} samples_t;
	typedef logic [15:0][31:0] lanes_t;
	typedef struct packed {
		logic [6:0] fmt_reg;
		logic sync_fec_reg;
		logic [1:0] bind_reg;
		logic [1:0] chan_pd_reg;
		logic [1:0] mode_reg;
		logic [2:0] pd_sync_reg;
		logic pd_pin_reg;
		logic pready_reg;
		logic pslverr_reg;
		logic [31:0] prdata_reg;
		lanes_t lane_reg;
		logic [15:0] lane_en_reg;
		logic frame_valid_reg;
		logic reinit_reg;
		logic drv_off_reg;
	} state_t;
endpackage

// *** rtl/lane_mapper.sv ***
// transport lane mapper with sync header, channel binding and power-down control
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "lane_map_consts.svh"

// ==========================================================================
// Overview of operation
// - format 21/36: A0,A1 carry I0,I1 words; B0,B1 carry Q0,Q1, own flags
// - format 22/46: A0-A3 carry I0-I3, B0-B3 Q0-Q3, matching flags
// - two-lane decimate-by-8 single formats: A0 I0 with flag, B0 Q0 with flag
// - format 24/48/62/65/70: A0,A1 I0,I1; B0,B1 Q0,Q1, own flags
// - format 25/52: A0-A7 I0-I7, B0-B7 Q0-Q7, flag shared by sample pairs
// - format 26/54/63: A0-A3 I0-I3, B0-B3 Q0-Q3, matching flags
// - format 27: A0-A7 I0-I7, B0-B7 Q0-Q7, flag of same index
// - format 32: even 12-bit samples packed MSB first on A0-A2, odd on B0-B2
// - format 33: channel A samples 0-3 packed on A0-A2, channel B on B0-B2
// - format 34: one octet per lane, S0 A0, S2 A1, S1 B0, S3 B1
// - format 35: one octet per lane, A0/A1 channel A, B0/B1 channel B
// - format 37: A0 AI, A1 AQ, B0 BI, B1 BQ, each with flag
// - format 39/56: four octets per lane, I word then Q word, A0 and B0
// - sync header mode selects CRC checking or forward error correction
// - only 12-bit CRC exists; no 3-bit CRC variant
// - dual-channel binding routes one channel to both down-converter paths
// - unused channel may be powered down without disturbing routed data
// - binding also gives redundant data on both links, not in single formats
// - power-down input high powers down and disables serial drivers
// - operating-mode field can command full power-down too
module lane_mapper
	import lane_map_pkg::*;
(
	input wire logic pclk, // bus and sample clock
	input wire logic presetn, // async reset
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [`ADDR_W-1:0] paddr, // apb byte address
	input wire logic [`REG_W-1:0] pwdata, // apb write data
	output logic [`REG_W-1:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic power_down_input, // asynchronous power-down pin
	input wire logic sample_valid, // one frame of samples present
	input wire lane_map_pkg::samples_t sample_in, // converter samples and flags
	output logic [31:0] lane_a_0, // lane word, first octet in msb
	output logic [31:0] lane_a_1, // lane word
	output logic [31:0] lane_a_2, // lane word
	output logic [31:0] lane_a_3, // lane word
	output logic [31:0] lane_a_4, // lane word
	output logic [31:0] lane_a_5, // lane word
	output logic [31:0] lane_a_6, // lane word
	output logic [31:0] lane_a_7, // lane word
	output logic [31:0] lane_b_0, // lane word
	output logic [31:0] lane_b_1, // lane word
	output logic [31:0] lane_b_2, // lane word
	output logic [31:0] lane_b_3, // lane word
	output logic [31:0] lane_b_4, // lane word
	output logic [31:0] lane_b_5, // lane word
	output logic [31:0] lane_b_6, // lane word
	output logic [31:0] lane_b_7, // lane word
	output logic [15:0] lane_enable, // lanes in use, b side in upper byte
	output logic frame_valid, // lane words updated this cycle
	output logic sync_hdr_fec, // 1 fec, 0 crc-12
	output logic serdes_disable, // serial drivers off
	output logic link_reinit // pulse on leaving power-down
);
	import lane_map_pkg::*;

	localparam state_t ST_RST = '{fmt_reg: `RST_FORMAT, default: '0};

	state_t st;
	state_t nx;
	fmt_class_t cls;
	logic single;
	logic pd_all;
	logic [3:0] nside;
	chan_t src_a;
	chan_t src_b;
	chan_t path_a;
	chan_t path_b;
	lanes_t lanes_nx;
	logic [7:0] side_mask;
	logic mapped;
	logic [`REG_W-1:0] rd;

	// ==================================================================
	// format decode
	function automatic fmt_class_t decode(input logic [6:0] f);
		fmt_class_t c;
		c = FC_NONE;
		case (f)
			`FMT_21, `FMT_36: c = FC_S4_4L;
			`FMT_22, `FMT_46: c = FC_S4_8L;
			`FMT_23, `FMT_38, `FMT_61, `FMT_64, `FMT_69, `FMT_71: c = FC_S8_2L;
			`FMT_24, `FMT_48, `FMT_62, `FMT_65, `FMT_70: c = FC_S8_4L;
			`FMT_25, `FMT_52: c = FC_S4_16L;
			`FMT_26, `FMT_54, `FMT_63: c = FC_S8_8L;
			`FMT_27: c = FC_S8_16L;
			`FMT_32: c = FC_B12_S6;
			`FMT_33: c = FC_B12_D6;
			`FMT_34: c = FC_B8_S4;
			`FMT_35: c = FC_B8_D4;
			`FMT_37: c = FC_D4_4L;
			`FMT_39, `FMT_56: c = FC_D_2L;
			default: c = FC_NONE;
		endcase
		return c;
	endfunction

	function automatic logic [3:0] lanes_per_side(input fmt_class_t c);
		logic [3:0] n;
		n = 4'h0;
		case (c)
			FC_S8_2L, FC_D_2L: n = 4'h1;
			FC_S4_4L, FC_S8_4L, FC_B8_S4, FC_B8_D4, FC_D4_4L: n = 4'h2;
			FC_B12_S6, FC_B12_D6: n = 4'h3;
			FC_S4_8L, FC_S8_8L: n = 4'h4;
			FC_S4_16L, FC_S8_16L: n = 4'h8;
			default: n = 4'h0;
		endcase
		return n;
	endfunction

	function automatic logic is_single(input fmt_class_t c);
		logic s;
		s = 1'b0;
		case (c)
			FC_S4_4L, FC_S4_8L, FC_S8_2L, FC_S8_4L, FC_S4_16L, FC_S8_8L,
			FC_S8_16L, FC_B12_S6, FC_B8_S4: s = 1'b1;
			default: s = 1'b0;
		endcase
		return s;
	endfunction

	// ==================================================================
	// sample to lane mapping
	function automatic lanes_t map_lanes(input fmt_class_t c, input chan_t pa,
			input chan_t pb, input logic [3:0] n);
		lanes_t l;
		logic [2:0][15:0] pk_a;
		logic [2:0][15:0] pk_b;
		int oi;
		l = '0;
		pk_a = '0;
		pk_b = '0;
		oi = 0;
		case (c)
			FC_B12_S6: begin
				pk_a = {pa.raw[0], pa.raw[2], pa.raw[4], pa.raw[6]};
				pk_b = {pa.raw[1], pa.raw[3], pa.raw[5], pa.raw[7]};
			end
			FC_B12_D6: begin
				pk_a = {pa.raw[0], pa.raw[1], pa.raw[2], pa.raw[3]};
				pk_b = {pb.raw[0], pb.raw[1], pb.raw[2], pb.raw[3]};
			end
			default: begin
			end
		endcase
		for (int k = 0; k < SIDE; k++) begin
			// pairs of samples share one flag in the 16-lane decimate-by-4 case
			oi = (c == FC_S4_16L) ? k / 2 : k;
			case (c)
				FC_S4_4L, FC_S4_8L, FC_S8_2L, FC_S8_4L, FC_S4_16L, FC_S8_8L,
				FC_S8_16L: begin
					if (k < int'(n)) begin
						l[k] = {pa.inphase[k], pa.overrange_flag_inphase[oi], `PAD16};
						l[SIDE+k] = {pa.quadrature[k], pa.overrange_flag_quadrature[oi],
							`PAD16};
					end
				end
				FC_B12_S6, FC_B12_D6: begin
					if (k < int'(n)) begin
						l[k] = {pk_a[2-k], `PAD16};
						l[SIDE+k] = {pk_b[2-k], `PAD16};
					end
				end
				default: begin
				end
			endcase
		end
		case (c)
			FC_B8_S4: begin
				l[0] = {pa.raw[0][11:4], `PAD24};
				l[1] = {pa.raw[2][11:4], `PAD24};
				l[SIDE] = {pa.raw[1][11:4], `PAD24};
				l[SIDE+1] = {pa.raw[3][11:4], `PAD24};
			end
			FC_B8_D4: begin
				l[0] = {pa.raw[0][11:4], `PAD24};
				l[1] = {pa.raw[1][11:4], `PAD24};
				l[SIDE] = {pb.raw[0][11:4], `PAD24};
				l[SIDE+1] = {pb.raw[1][11:4], `PAD24};
			end
			FC_D4_4L: begin
				l[0] = {pa.inphase[0], pa.overrange_flag_inphase[0], `PAD16};
				l[1] = {pa.quadrature[0], pa.overrange_flag_quadrature[0], `PAD16};
				l[SIDE] = {pb.inphase[0], pb.overrange_flag_inphase[0], `PAD16};
				l[SIDE+1] = {pb.quadrature[0], pb.overrange_flag_quadrature[0], `PAD16};
			end
			FC_D_2L: begin
				l[0] = {pa.inphase[0], pa.overrange_flag_inphase[0],
					pa.quadrature[0], pa.overrange_flag_quadrature[0]};
				l[SIDE] = {pb.inphase[0], pb.overrange_flag_inphase[0],
					pb.quadrature[0], pb.overrange_flag_quadrature[0]};
			end
			default: begin
			end
		endcase
		return l;
	endfunction

	// ==================================================================
	// routing and power-down
	assign cls = decode(st.fmt_reg);
	assign single = is_single(cls);
	assign nside = lanes_per_side(cls);
	assign side_mask = 8'((9'h001 << nside) - 9'h001);
	assign pd_all = st.pd_pin_reg || (st.mode_reg != `MODE_NORMAL);
	// a powered-down channel is blanked before routing, so the routed one is untouched
	assign src_a = st.chan_pd_reg[`PD_A_BIT] ? '0 : sample_in.chan_a;
	assign src_b = st.chan_pd_reg[`PD_B_BIT] ? '0 : sample_in.chan_b;
	// binding ignored in single-channel formats; first-path bind wins
	assign path_a = (!single && st.bind_reg[`BIND_B_BIT] && !st.bind_reg[`BIND_A_BIT])
		? src_b : src_a;
	assign path_b = (!single && st.bind_reg[`BIND_A_BIT]) ? src_a : src_b;
	assign lanes_nx = map_lanes(cls, path_a, path_b, nside);
	assign mapped = (paddr == `OFS_FORMAT) || (paddr == `OFS_SYNC) || (paddr == `OFS_BIND)
		|| (paddr == `OFS_CHPD) || (paddr == `OFS_DEVCFG) || (paddr == `OFS_STATUS);

	// ==================================================================
	// next state
	always_comb begin
		nx = st;
		rd = '0;
		case (paddr)
			`OFS_FORMAT: rd = `REG_W'(st.fmt_reg);
			`OFS_SYNC: rd = `REG_W'(st.sync_fec_reg);
			`OFS_BIND: rd = `REG_W'(st.bind_reg);
			`OFS_CHPD: rd = `REG_W'(st.chan_pd_reg);
			`OFS_DEVCFG: rd = `REG_W'(st.mode_reg);
			`OFS_STATUS: begin
				rd[`ST_PD] = pd_all;
				rd[`ST_SUP] = (cls != FC_NONE);
				rd[`ST_RED] = !single && (st.bind_reg != 2'h0);
				rd[`ST_PIN] = st.pd_pin_reg;
				rd[`ST_FEC] = st.sync_fec_reg;
				rd[`ST_CLS +: $bits(fmt_class_t)] = cls;
			end
			default: rd = '0;
		endcase
		// pin synchroniser: a change counts once stages two and three agree
		nx.pd_sync_reg = {st.pd_sync_reg[1:0], power_down_input};
		if (st.pd_sync_reg[1] == st.pd_sync_reg[2]) begin
			nx.pd_pin_reg = st.pd_sync_reg[2];
		end
		// apb: answer one cycle into the access phase, commit on the completing edge
		if (psel && penable && !st.pready_reg) begin
			nx.pready_reg = 1'b1;
			nx.pslverr_reg = !mapped || (pwrite && paddr == `OFS_STATUS);
			nx.prdata_reg = pwrite ? '0 : rd;
		end else if (psel && penable && st.pready_reg) begin
			nx.pready_reg = 1'b0;
			nx.pslverr_reg = 1'b0;
			nx.prdata_reg = '0;
			if (pwrite && !st.pslverr_reg) begin
				case (paddr)
					`OFS_FORMAT: nx.fmt_reg = pwdata[6:0];
					`OFS_SYNC: nx.sync_fec_reg = pwdata[`SYNC_BIT];
					`OFS_BIND: nx.bind_reg = pwdata[1:0];
					`OFS_CHPD: nx.chan_pd_reg = pwdata[1:0];
					`OFS_DEVCFG: nx.mode_reg = pwdata[1:0];
					default: begin
					end
				endcase
			end
		end
		// lanes
		nx.frame_valid_reg = 1'b0;
		nx.drv_off_reg = pd_all;
		nx.reinit_reg = st.drv_off_reg && !pd_all;
		if (pd_all) begin
			nx.lane_reg = '0;
			nx.lane_en_reg = '0;
		end else if (cls == FC_NONE) begin
			nx.lane_en_reg = '0;
		end else if (sample_valid) begin
			nx.lane_reg = lanes_nx;
			nx.lane_en_reg = {side_mask, side_mask};
			nx.frame_valid_reg = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= ST_RST;
		end else begin
			st <= nx;
		end
	end

	// ==================================================================
	// outputs
	assign prdata = st.prdata_reg;
	assign pready = st.pready_reg;
	assign pslverr = st.pslverr_reg;
	assign lane_a_0 = st.lane_reg[0];
	assign lane_a_1 = st.lane_reg[1];
	assign lane_a_2 = st.lane_reg[2];
	assign lane_a_3 = st.lane_reg[3];
	assign lane_a_4 = st.lane_reg[4];
	assign lane_a_5 = st.lane_reg[5];
	assign lane_a_6 = st.lane_reg[6];
	assign lane_a_7 = st.lane_reg[7];
	assign lane_b_0 = st.lane_reg[SIDE];
	assign lane_b_1 = st.lane_reg[SIDE+1];
	assign lane_b_2 = st.lane_reg[SIDE+2];
	assign lane_b_3 = st.lane_reg[SIDE+3];
	assign lane_b_4 = st.lane_reg[SIDE+4];
	assign lane_b_5 = st.lane_reg[SIDE+5];
	assign lane_b_6 = st.lane_reg[SIDE+6];
	assign lane_b_7 = st.lane_reg[SIDE+7];
	assign lane_enable = st.lane_en_reg;
	assign frame_valid = st.frame_valid_reg;
	assign sync_hdr_fec = st.sync_fec_reg;
	assign serdes_disable = st.drv_off_reg;
	assign link_reinit = st.reinit_reg;

	// ==================================================================
	// assertions
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence frame_in(fmt_class_t c);
		sample_valid && !pd_all && cls == c && st.chan_pd_reg == 2'h0 && st.bind_reg == 2'h0;
	endsequence

	sequence sync_write;
		psel && penable && pready && pwrite && !pslverr && paddr == `OFS_SYNC;
	endsequence

	map_fmt21_a: assert property (frame_in(FC_S4_4L) |=>
		lane_a_1 == {$past(sample_in.chan_a.inphase[1]),
			$past(sample_in.chan_a.overrange_flag_inphase[1]), `PAD16}
		&& lane_b_0[31:16] == {$past(sample_in.chan_a.quadrature[0]),
			$past(sample_in.chan_a.overrange_flag_quadrature[0])} && frame_valid)
		else $error("format 21 lane words wrong");
	map_fmt22_a: assert property (frame_in(FC_S4_8L) |=>
		lane_enable == 16'h0F0F && lane_b_3[31:17] == $past(sample_in.chan_a.quadrature[3]))
		else $error("format 22 lanes wrong");
	map_fmt23_a: assert property (frame_in(FC_S8_2L) |=>
		lane_enable == 16'h0101 && lane_a_0[16] == $past(sample_in.chan_a.overrange_flag_inphase[0]))
		else $error("format 23 lanes wrong");
	pair_flag_a: assert property (frame_in(FC_S4_16L) |=>
		lane_a_3[16] == $past(sample_in.chan_a.overrange_flag_inphase[1])
		&& lane_b_6[16] == $past(sample_in.chan_a.overrange_flag_quadrature[3]))
		else $error("shared flag wrong");
	pack_fmt32_a: assert property (frame_in(FC_B12_S6) |=>
		{lane_a_0[31:16], lane_a_1[31:16], lane_a_2[31:16]} ==
		$past({sample_in.chan_a.raw[0], sample_in.chan_a.raw[2],
			sample_in.chan_a.raw[4], sample_in.chan_a.raw[6]}))
		else $error("format 32 packing wrong");
	octet_fmt34_a: assert property (frame_in(FC_B8_S4) |=>
		lane_a_1[31:24] == $past(sample_in.chan_a.raw[2][11:4])
		&& lane_b_0[31:24] == $past(sample_in.chan_a.raw[1][11:4]))
		else $error("format 34 octets wrong");
	map_fmt37_a: assert property (frame_in(FC_D4_4L) |=>
		lane_a_1[31:17] == $past(sample_in.chan_a.quadrature[0])
		&& lane_b_0[31:17] == $past(sample_in.chan_b.inphase[0]))
		else $error("format 37 lanes wrong");
	map_fmt39_a: assert property (frame_in(FC_D_2L) |=>
		lane_b_0[15:1] == $past(sample_in.chan_b.quadrature[0]) && lane_enable == 16'h0101)
		else $error("format 39 lanes wrong");
	bind_route_a: assert property (sample_valid && !pd_all && cls == FC_D4_4L
		&& st.bind_reg[`BIND_A_BIT] && !st.chan_pd_reg[`PD_A_BIT] |=>
		lane_b_0[31:17] == $past(sample_in.chan_a.inphase[0]))
		else $error("channel binding not applied");
	pin_power_a: assert property (power_down_input [*6] |->
		serdes_disable && lane_enable == 16'h0000)
		else $error("power-down pin did not disable drivers");
	mode_power_a: assert property (st.mode_reg != `MODE_NORMAL ##1 st.mode_reg != `MODE_NORMAL
		|-> serdes_disable && !frame_valid)
		else $error("mode power-down not applied");
	sync_mode_a: assert property (sync_write |=> sync_hdr_fec == $past(pwdata[`SYNC_BIT]))
		else $error("sync header mode not taken");
	reinit_pulse_a: assert property ($fell(serdes_disable) |-> link_reinit ##1 !link_reinit)
		else $error("link restart pulse wrong");
endmodule

// *** tb/link_receiver.sv ***
// far-side lane receiver model that drops stale frames after a link restart
`timescale 1ns/1ps
module link_receiver #(
	parameter int DISCARD = 4
) (
	input wire logic pclk, // sample clock
	input wire logic presetn, // async reset
	input wire logic frame_valid, // new lane words
	input wire logic link_reinit, // link restart pulse
	input wire logic serdes_disable, // drivers off
	input wire logic sync_hdr_fec, // header mode
	output logic [15:0] kept // frames accepted
);
	// converter-off calibration field always set before power-down use
	localparam logic CAL_CONVERTER_OFF = 1'b1;
	logic [3:0] drop;
	logic crc12_only;
	// header checker knows crc-12 only, never the 3-bit variant
	assign crc12_only = !sync_hdr_fec;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drop <= '0;
			kept <= '0;
		end else if (link_reinit) begin
			drop <= 4'(DISCARD); // relink, then flush the pipeline
		end else if (frame_valid && !serdes_disable && CAL_CONVERTER_OFF && crc12_only) begin
			if (drop != 4'h0) begin
				drop <= drop - 4'h1; // stale samples thrown away
			end else begin
				kept <= kept + 16'h0001;
			end
		end
	end
endmodule

// *** tb/adc_lane_mapper_and_link_control_tb.sv ***
// self-checking bench for the lane mapper
`timescale 1ns/1ps
`include "lane_map_consts.svh"
module adc_lane_mapper_and_link_control_tb;
	import lane_map_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, power_down_input, sample_valid;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic pready, pslverr, e, frame_valid, sync_hdr_fec, serdes_disable, link_reinit;
	logic [15:0] lane_enable, kept;
	samples_t sample_in;
	wire lanes_t obs;
	lanes_t lq[$];
	logic [15:0] eq[$];
	logic [6:0] fmt;
	logic [1:0] bnd, chpd;
	int seed = 54270;
	int err_count = 0;
	int comparisons = 0;
	logic [6:0] fl[28] = '{`FMT_21, `FMT_36, `FMT_22, `FMT_46,
		`FMT_23, `FMT_38, `FMT_61, `FMT_64, `FMT_69, `FMT_71,
		`FMT_24, `FMT_48, `FMT_62, `FMT_65, `FMT_70, `FMT_25, `FMT_52,
		`FMT_26, `FMT_54, `FMT_63, `FMT_27, `FMT_32, `FMT_33,
		`FMT_34, `FMT_35, `FMT_37, `FMT_39, `FMT_56};

	lane_mapper lane_mapper_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .power_down_input(power_down_input), .sample_valid(sample_valid),
		.sample_in(sample_in), .lane_a_0(obs[0]), .lane_a_1(obs[1]), .lane_a_2(obs[2]),
		.lane_a_3(obs[3]), .lane_a_4(obs[4]), .lane_a_5(obs[5]), .lane_a_6(obs[6]),
		.lane_a_7(obs[7]), .lane_b_0(obs[8]), .lane_b_1(obs[9]), .lane_b_2(obs[10]),
		.lane_b_3(obs[11]), .lane_b_4(obs[12]), .lane_b_5(obs[13]), .lane_b_6(obs[14]),
		.lane_b_7(obs[15]), .lane_enable(lane_enable), .frame_valid(frame_valid),
		.sync_hdr_fec(sync_hdr_fec), .serdes_disable(serdes_disable), .link_reinit(link_reinit));

	link_receiver #(.DISCARD(4)) link_receiver_i (.pclk(pclk), .presetn(presetn),
		.frame_valid(frame_valid), .link_reinit(link_reinit), .serdes_disable(serdes_disable),
		.sync_hdr_fec(sync_hdr_fec), .kept(kept));

	// ==========================================================
	// helpers
	task automatic chk(input logic [527:0] g, input logic [527:0] x);
		comparisons++;
		if (g !== x) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask

	task results;
		$display("checks=%0d errors=%0d frames_kept=%0d", comparisons, err_count, kept);
		if (err_count == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			t++;
		end while (pready !== 1'b1);
		// one wait state: pready seen on the second access edge
		chk(528'(t), 528'(2));
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task cfg(input logic [6:0] f, input logic [1:0] b, input logic [1:0] p);
		fmt = f;
		bnd = b;
		chpd = p;
		apb(1'b1, `OFS_FORMAT, 32'(f));
		apb(1'b1, `OFS_BIND, 32'(b));
		apb(1'b1, `OFS_CHPD, 32'(p));
	endtask

	function automatic logic [15:0] wd(input chan_t c, input logic q, input int k, input int j);
		return q ? {c.quadrature[k], c.overrange_flag_quadrature[j]} :
			{c.inphase[k], c.overrange_flag_inphase[j]};
	endfunction

	function automatic void calc(input logic [6:0] f, input samples_t s, output lanes_t l,
			output logic [15:0] en);
		chan_t a;
		chan_t b;
		logic [47:0] pa;
		logic [47:0] pb;
		int n;
		logic sh;
		a = chpd[0] ? '0 : s.chan_a;
		b = chpd[1] ? '0 : s.chan_b;
		l = '0;
		en = '0;
		n = 0;
		sh = 1'b0;
		pa = '0;
		pb = '0;
		if (f inside {`FMT_33, `FMT_35, `FMT_37, `FMT_39, `FMT_56}) begin
			if (bnd[0]) b = a;
			else if (bnd[1]) a = b;
		end
		case (f)
			`FMT_21, `FMT_36, `FMT_24, `FMT_48, `FMT_62, `FMT_65, `FMT_70: n = 2;
			`FMT_22, `FMT_46, `FMT_26, `FMT_54, `FMT_63: n = 4;
			`FMT_23, `FMT_38, `FMT_61, `FMT_64, `FMT_69, `FMT_71: n = 1;
			`FMT_25, `FMT_52: begin
				n = 8;
				sh = 1'b1;
			end
			`FMT_27: n = 8;
			`FMT_32: begin
				pa = {a.raw[0], a.raw[2], a.raw[4], a.raw[6]};
				pb = {a.raw[1], a.raw[3], a.raw[5], a.raw[7]};
				en = 16'h0707;
			end
			`FMT_33: begin
				pa = {a.raw[0], a.raw[1], a.raw[2], a.raw[3]};
				pb = {b.raw[0], b.raw[1], b.raw[2], b.raw[3]};
				en = 16'h0707;
			end
			`FMT_34, `FMT_35: begin
				l[0] = {a.raw[0][11:4], `PAD24};
				l[1] = {(f == `FMT_34) ? a.raw[2][11:4] : a.raw[1][11:4], `PAD24};
				l[8] = {(f == `FMT_34) ? a.raw[1][11:4] : b.raw[0][11:4], `PAD24};
				l[9] = {(f == `FMT_34) ? a.raw[3][11:4] : b.raw[1][11:4], `PAD24};
				en = 16'h0303;
			end
			`FMT_37: begin
				l[0] = {wd(a, 1'b0, 0, 0), `PAD16};
				l[1] = {wd(a, 1'b1, 0, 0), `PAD16};
				l[8] = {wd(b, 1'b0, 0, 0), `PAD16};
				l[9] = {wd(b, 1'b1, 0, 0), `PAD16};
				en = 16'h0303;
			end
			`FMT_39, `FMT_56: begin
				l[0] = {wd(a, 1'b0, 0, 0), wd(a, 1'b1, 0, 0)};
				l[8] = {wd(b, 1'b0, 0, 0), wd(b, 1'b1, 0, 0)};
				en = 16'h0101;
			end
			default: ;
		endcase
		if (en == 16'h0707) begin
			for (int k = 0; k < 3; k++) begin
				l[k] = {pa[47 - 16 * k -: 16], `PAD16};
				l[8 + k] = {pb[47 - 16 * k -: 16], `PAD16};
			end
		end
		for (int k = 0; k < n; k++) begin
			l[k] = {wd(a, 1'b0, k, sh ? k / 2 : k), `PAD16};
			l[8 + k] = {wd(a, 1'b1, k, sh ? k / 2 : k), `PAD16};
			en[k] = 1'b1;
			en[8 + k] = 1'b1;
		end
	endfunction

	// back-to-back frames; x says whether lane words are expected
	task frames(input int n, input logic x);
		samples_t s;
		lanes_t l;
		logic [15:0] en;
		repeat (n) begin
			for (int k = 0; k < 22; k++) s[k * 32 +: 32] = $random(seed);
			@(posedge pclk);
			sample_valid <= 1'b1;
			sample_in <= s;
			if (x) begin
				calc(fmt, s, l, en);
				lq.push_back(l);
				eq.push_back(en);
			end
		end
		@(posedge pclk);
		sample_valid <= 1'b0;
	endtask

	task wait_reinit;
		int t;
		t = 0;
		while (link_reinit !== 1'b1 && t < 20) begin
			@(posedge pclk);
			t++;
		end
		chk(528'(link_reinit), 528'(1));
		chk(528'(serdes_disable), 528'(0));
	endtask

	// ==========================================================
	// clock, monitor, watchdog
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		if (frame_valid === 1'b1) begin
			if (lq.size() == 0) chk(528'(1), 528'(0));
			else chk({obs, lane_enable}, {lq.pop_front(), eq.pop_front()});
		end
	end

	initial begin
		#2000000;
		err_count++;
		results();
	end

	// ==========================================================
	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, power_down_input, sample_valid} = '0;
		{paddr, pwdata, sample_in} = '0;
		fmt = `RST_FORMAT;
		bnd = '0;
		chpd = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `OFS_FORMAT, 32'h0);
		chk(528'(r), 528'(`RST_FORMAT));
		chk(528'(sync_hdr_fec), 528'(0));
		for (int i = 0; i < 28; i++) begin
			cfg(fl[i], 2'h0, 2'h0);
			frames(2, 1'b1);
		end
		cfg(`FMT_37, 2'h1, 2'h0);
		frames(2, 1'b1);
		cfg(`FMT_37, 2'h2, 2'h0);
		frames(1, 1'b1);
		cfg(`FMT_37, 2'h1, 2'h2);
		frames(2, 1'b1);
		cfg(`FMT_33, 2'h2, 2'h1);
		frames(1, 1'b1);
		cfg(`FMT_39, 2'h1, 2'h0);
		frames(1, 1'b1);
		cfg(`FMT_21, 2'h1, 2'h0);
		frames(1, 1'b1);
		apb(1'b1, `OFS_SYNC, 32'h1);
		repeat (2) @(posedge pclk);
		chk(528'(sync_hdr_fec), 528'(1));
		apb(1'b0, `OFS_SYNC, 32'h0);
		chk(528'(r), 528'(1));
		apb(1'b1, `OFS_SYNC, 32'h0);
		repeat (2) @(posedge pclk);
		chk(528'(sync_hdr_fec), 528'(0));
		cfg(7'h00, 2'h0, 2'h0);
		frames(1, 1'b0);
		repeat (2) @(posedge pclk);
		chk(528'(lane_enable), 528'(0));
		cfg(`FMT_22, 2'h0, 2'h0);
		frames(1, 1'b1);
		power_down_input <= 1'b1;
		repeat (7) @(posedge pclk);
		chk(528'(serdes_disable), 528'(1));
		chk({obs, lane_enable}, 528'(0));
		frames(1, 1'b0);
		power_down_input <= 1'b0;
		wait_reinit();
		frames(1, 1'b1);
		apb(1'b1, `OFS_DEVCFG, 32'h1);
		repeat (2) @(posedge pclk);
		chk(528'(serdes_disable), 528'(1));
		chk(528'(lane_enable), 528'(0));
		apb(1'b0, `OFS_STATUS, 32'h0);
		chk(528'(r), 528'({FC_S4_8L, 8'h03}));
		apb(1'b1, `OFS_DEVCFG, 32'h0);
		wait_reinit();
		frames(2, 1'b1);
		apb(1'b0, 8'h18, 32'h0);
		chk(528'({r, e}), 528'({32'h0, 1'b1}));
		apb(1'b1, `OFS_STATUS, 32'hFFFFFFFF);
		chk(528'(e), 528'(1));
		repeat (3) @(posedge pclk);
		chk(528'(lq.size()), 528'(0));
		// frames after each restart fall inside the discard span
		chk(528'(kept), 528'(65));
		results();
	end
endmodule
